//--- src/uart_aux_params.svh
`ifndef UART_AUX_PARAMS_SVH
`define UART_AUX_PARAMS_SVH
// register byte addresses
`define ADDR_CTRL       8'h00
`define ADDR_IRCFG      8'h04
`define ADDR_WATERMARK  8'h08
`define ADDR_STATUS     8'h0C
// control register field positions
`define CTRL_EVT_RX_EN  0
`define CTRL_TX_TRIG_EN 1
`define CTRL_RX_TRIG_EN 2
`define CTRL_RX_DMA_WU  3
`define CTRL_TX_DMA_WU  4
`define CTRL_LP_CAPABLE 5
`define CTRL_LF_CLOCK   6
`define CTRL_WAKE_EN    7
// infrared config field positions
`define IR_FAST_EN      0
`define IR_SLOW_EN      1
`define IR_FILT_EN      2
`define IR_PW_LO        3
`define IR_OVS_LO       5
// reset values
`define CTRL_RESET      8'h00
`define IRCFG_RESET     8'h00
`define WM_RESET        4'h0
// glitch filter persistence in clk_in cycles
`define FILT_CYCLES     3'd5
// oversample period counts, one per oversample select code
`define OVS16_CNT       5'd16
`define OVS8_CNT        5'd8
`define OVS6_CNT        5'd6
`define OVS4_CNT        5'd4
`endif

//--- src/uart_aux_pkg.sv
`default_nettype none
package uart_aux_pkg;
  // mode of the demodulator sequencing
  typedef enum logic [1:0] {DM_IDLE, DM_FILT, DM_HOLD} demod_state_e;
  // event fabric outputs travel together
  typedef struct packed {
    logic serial_out;
    logic send_complete;
    logic infrared_out;
    logic receive_level;
    logic request_to_send;
  } event_out_s;
  // wake causes from the core
  typedef struct packed {
    logic frame_done;
    logic start_frame;
    logic signal_frame;
  } wake_cause_s;
endpackage : uart_aux_pkg
`default_nettype wire

//--- src/uart_irda_event_lowpower.sv
// Function
// - deep sleep only for capable instance on slow clock
// - wake on frame, start or signal frame
// - enabled interrupts wake, one shot each
// - DMA wake bits hold off deep sleep
// - event fabric inputs synchronized first
// - event receive enable picks fabric rx source
// - trigger edge enables tx and rx
// - event outputs come from flip-flops
// - receive level when count exceeds watermark
// - slow infrared is receive only, 32.768 kHz
// - break disabled while any infrared enabled
// - fast codec converts level to pulse coding
// - one idles, zero is short pulse
// - fast enable routes through modulator, demodulator
// - pulse width is n+1 oversample periods, capped at 3, 2 and 1 for oversample select codes 1 to 3
// - optional filter needs five cycle persistence
// - pulses are always negative
// - slow infrared receive works in deep sleep
`timescale 1ns/10ps
`default_nettype none
`include "uart_aux_params.svh"
module uart_irda_event_lowpower #(
  parameter int FIFO_CNT_W = 4  // receive FIFO count width
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  // wishbone slave
  input  wire logic                  wb_cyc_in,
  input  wire logic                  wb_stb_in,
  input  wire logic                  wb_we_in,
  input  wire logic [7:0]            wb_adr_in,
  input  wire logic [3:0]            wb_sel_in,
  input  wire logic [31:0]           wb_dat_in,
  output logic      [31:0]           wb_dat_out,
  output logic                       wb_ack_out,
  // core side
  input  wire logic                  core_tx_in,
  input  wire logic                  core_rts_in,
  input  wire logic                  core_txc_in,
  input  wire logic [FIFO_CNT_W:0]   rx_fifo_cnt_in,
  input  wire logic                  bit_start_in,
  input  wire logic                  ovs_tick_in,
  input  wire logic                  slow_sample_in,
  input  wire uart_aux_pkg::wake_cause_s wake_cause_in,
  input  wire logic                  irq_pending_in,
  input  wire logic                  rx_dma_req_in,
  input  wire logic                  tx_dma_req_in,
  input  wire logic                  deep_sleep_state_in,
  output logic                       core_rx_out,
  output logic                       tx_enable_out,
  output logic                       rx_enable_out,
  output logic                       break_allow_out,
  // power manager
  output logic                       wake_req_out,
  output logic                       sleep_block_out,
  // line pins
  input  wire logic                  rx_pin_in,
  output logic                       tx_pin_out,
  // event fabric
  input  wire logic                  evt_rx_in,
  input  wire logic                  evt_trig_in,
  output uart_aux_pkg::event_out_s   evt_out
);
  // registers
  logic [7:0]            ctrl_r;   // control bits
  logic [7:0]            ircfg_r;  // infrared config
  logic [FIFO_CNT_W-1:0] wm_r;     // receive watermark
  logic                  ack_r;    // bus ack
  logic [31:0]           rdat_r;   // bus read data
  // synchronizers for fabric inputs
  logic evt_rx_m_r, evt_rx_s_r, trig_m_r, trig_s_r, trig_d_r;
  // registered outputs for core, line pin and power manager
  logic tx_en_r, rx_en_r, brk_r, rx_sel_r, txp_r, wake_r, blk_r;
  uart_aux_pkg::event_out_s evt_r;
  // infrared datapath
  logic [4:0] pw_cnt_r;    // pulse remaining in oversample periods
  logic [2:0] filt_cnt_r;  // filter persistence count
  logic       zero_seen_r; // pulse caught this bit
  logic       demod_r;     // demodulated level
  uart_aux_pkg::demod_state_e dm_r;
  logic [2:0] wake_d_r;    // previous wake causes for edges
  logic       irq_d_r;

  wire fast_en = ircfg_r[`IR_FAST_EN];
  wire slow_en = ircfg_r[`IR_SLOW_EN];
  wire filt_en = ircfg_r[`IR_FILT_EN];
  wire [1:0] pw  = ircfg_r[`IR_PW_LO+1:`IR_PW_LO];
  wire [1:0] oversample_select = ircfg_r[`IR_OVS_LO+1:`IR_OVS_LO];
  wire bus_req = wb_cyc_in && wb_stb_in && !ack_r;

  // pulse length in oversample periods, clamped to table's legal entries
  function automatic logic [4:0] pulse_len(input logic [1:0] n, input logic [1:0] o);
    logic [4:0] len;
    len = {3'b000, n} + 5'd1;
    case (o)
      2'd0: pulse_len = len;
      2'd1: pulse_len = (n == 2'd3) ? 5'd3 : len;
      2'd2: pulse_len = (n > 2'd1) ? 5'd2 : len;
      default: pulse_len = 5'd1;
    endcase
  endfunction : pulse_len

  // bus ack: single wait state, dropped after one cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // register writes with byte lane 0 steering the low fields
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_r  <= `CTRL_RESET;
      ircfg_r <= `IRCFG_RESET;
      wm_r    <= `WM_RESET;
    end else if (bus_req && wb_we_in && wb_sel_in[0]) begin
      case (wb_adr_in)
        `ADDR_CTRL:      ctrl_r  <= wb_dat_in[7:0];
        `ADDR_IRCFG:     ircfg_r <= wb_dat_in[7:0];
        `ADDR_WATERMARK: wm_r    <= wb_dat_in[FIFO_CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdat_r <= 32'h0000_0000;
    end else if (bus_req) begin
      case (wb_adr_in)
        `ADDR_CTRL:      rdat_r <= {24'h00_0000, ctrl_r};
        `ADDR_IRCFG:     rdat_r <= {24'h00_0000, ircfg_r};
        `ADDR_WATERMARK: rdat_r <= {{(32-FIFO_CNT_W){1'b0}}, wm_r};
        `ADDR_STATUS:    rdat_r <= {26'h000_0000, blk_r, wake_r, tx_en_r, rx_en_r,
                                    demod_r, evt_r.receive_level};
        default:         rdat_r <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdat_r;

  // two-stage synchronizers; first stages feed only second stages
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      evt_rx_m_r <= 1'b1;
      evt_rx_s_r <= 1'b1;
      trig_m_r   <= 1'b0;
      trig_s_r   <= 1'b0;
      trig_d_r   <= 1'b0;
    end else begin
      evt_rx_m_r <= evt_rx_in;
      evt_rx_s_r <= evt_rx_m_r;
      trig_m_r   <= evt_trig_in;
      trig_s_r   <= trig_m_r;
      trig_d_r   <= trig_s_r;
    end
  end

  // trigger rising edge sets enables; they stay until reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
    end else if (trig_s_r && !trig_d_r) begin
      if (ctrl_r[`CTRL_TX_TRIG_EN]) tx_en_r <= 1'b1;
      if (ctrl_r[`CTRL_RX_TRIG_EN]) rx_en_r <= 1'b1;
    end
  end

  // modulator: zero bit gives pulse at bit start, one keeps idle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pw_cnt_r <= 5'd0;
    end else if (bit_start_in && !core_tx_in) begin
      pw_cnt_r <= pulse_len(pw, oversample_select);
    end else if (ovs_tick_in && pw_cnt_r != 5'd0) begin
      pw_cnt_r <= pw_cnt_r - 5'd1;
    end
  end

  // line output: negative pulse from the idle-high level
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      txp_r <= 1'b1;
    end else if (fast_en) begin
      // the pulse ends on the tick that closes its last oversample period, not a clock later
      txp_r <= !((bit_start_in && !core_tx_in) || pw_cnt_r > 5'd1
                 || (pw_cnt_r == 5'd1 && !ovs_tick_in));
    end else begin
      txp_r <= core_tx_in;
    end
  end
  assign tx_pin_out = txp_r;

  // demodulator: a low pulse marks the bit as zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dm_r        <= uart_aux_pkg::DM_IDLE;
      filt_cnt_r  <= 3'd0;
      zero_seen_r <= 1'b0;
    end else begin
      if (bit_start_in) zero_seen_r <= 1'b0;
      case (dm_r)
        uart_aux_pkg::DM_IDLE: begin
          filt_cnt_r <= 3'd1;
          if (!rx_pin_in) begin
            if (filt_en) dm_r <= uart_aux_pkg::DM_FILT;
            else begin
              zero_seen_r <= 1'b1;
              dm_r        <= uart_aux_pkg::DM_HOLD;
            end
          end
        end
        uart_aux_pkg::DM_FILT: begin
          if (rx_pin_in) dm_r <= uart_aux_pkg::DM_IDLE;
          else if (filt_cnt_r == `FILT_CYCLES - 3'd1) begin
            zero_seen_r <= 1'b1;
            dm_r        <= uart_aux_pkg::DM_HOLD;
          end else filt_cnt_r <= filt_cnt_r + 3'd1;
        end
        uart_aux_pkg::DM_HOLD: if (rx_pin_in) dm_r <= uart_aux_pkg::DM_IDLE;
        default: dm_r <= uart_aux_pkg::DM_IDLE;
      endcase
    end
  end

  // demodulated level held for the bit
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      demod_r <= 1'b1;
    end else begin
      demod_r <= !(zero_seen_r || (dm_r == uart_aux_pkg::DM_HOLD));
    end
  end

  // receive source choice: fabric, infrared fast, slow sampled, or pin
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_sel_r <= 1'b1;
    end else if (ctrl_r[`CTRL_EVT_RX_EN]) begin
      rx_sel_r <= evt_rx_s_r;
    end else if (fast_en) begin
      rx_sel_r <= demod_r;
    end else if (slow_en) begin
      if (slow_sample_in) rx_sel_r <= demod_r;
    end else begin
      rx_sel_r <= rx_pin_in;
    end
  end
  assign core_rx_out = rx_sel_r;

  // break allowed only with infrared off
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      brk_r <= 1'b1;
    end else begin
      brk_r <= !(fast_en || slow_en);
    end
  end

  // wake request: one-cycle pulse per new cause while asleep
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wake_d_r <= 3'b000;
      irq_d_r  <= 1'b0;
      wake_r   <= 1'b0;
    end else begin
      wake_d_r <= wake_cause_in;
      irq_d_r  <= irq_pending_in;
      wake_r   <= deep_sleep_state_in && ctrl_r[`CTRL_LP_CAPABLE] && ctrl_r[`CTRL_LF_CLOCK]
                  && (((wake_cause_in & ~wake_d_r) != 3'b000)
                      || (ctrl_r[`CTRL_WAKE_EN] && irq_pending_in && !irq_d_r));
    end
  end

  // deep sleep hold-off while related DMA requests are outstanding
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      blk_r <= 1'b0;
    end else begin
      blk_r <= (ctrl_r[`CTRL_RX_DMA_WU] && rx_dma_req_in)
               || (ctrl_r[`CTRL_TX_DMA_WU] && tx_dma_req_in);
    end
  end

  // event outputs, all flip-flops
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      evt_r <= '{serial_out: 1'b1, send_complete: 1'b0, infrared_out: 1'b1,
                 receive_level: 1'b0, request_to_send: 1'b1};
    end else begin
      evt_r.serial_out      <= core_tx_in;
      evt_r.send_complete   <= core_txc_in;
      evt_r.infrared_out    <= txp_r;
      evt_r.request_to_send <= core_rts_in;
      evt_r.receive_level   <= rx_fifo_cnt_in > {1'b0, wm_r};
    end
  end
  assign evt_out         = evt_r;
  assign tx_enable_out   = tx_en_r;
  assign rx_enable_out   = rx_en_r;
  assign break_allow_out = brk_r;
  assign wake_req_out    = wake_r;
  assign sleep_block_out = blk_r;

  // checks
  chk_level_event: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 evt_r.receive_level == ($past(rx_fifo_cnt_in) > {1'b0, $past(wm_r)}))
    else $error("receive level event wrong");
  chk_dma_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ctrl_r[`CTRL_RX_DMA_WU] && rx_dma_req_in) |=> blk_r)
    else $error("sleep not held off");
  chk_break_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (fast_en || slow_en) |=> !brk_r)
    else $error("break allowed during infrared");
  chk_trig_tx: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (trig_s_r && !trig_d_r && ctrl_r[`CTRL_TX_TRIG_EN]) |=> tx_en_r)
    else $error("trigger missed");
  chk_one_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (fast_en && pw_cnt_r == 5'd0 && !(bit_start_in && !core_tx_in)) |=> txp_r)
    else $error("one bit not idle");
  chk_zero_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (fast_en && bit_start_in && !core_tx_in) |=> !txp_r)
    else $error("zero pulse missing");
  // a zero from the filter must follow five low samples in a row
  chk_filter_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ($rose(zero_seen_r) && $past(filt_en)) |-> !$past(rx_pin_in, 1) && !$past(rx_pin_in, 2)
    && !$past(rx_pin_in, 3) && !$past(rx_pin_in, 4) && !$past(rx_pin_in, 5))
    else $error("filter accepted early");
  chk_wake_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !deep_sleep_state_in |=> !wake_r)
    else $error("wake outside sleep");
  chk_dma_tx: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ctrl_r[`CTRL_TX_DMA_WU] && tx_dma_req_in) |=> blk_r)
    else $error("sleep not held off for transmit");
  chk_dma_free: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !((ctrl_r[`CTRL_RX_DMA_WU] && rx_dma_req_in)
      || (ctrl_r[`CTRL_TX_DMA_WU] && tx_dma_req_in)) |=> !blk_r)
    else $error("sleep held off without a request");
  chk_event_copy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 (evt_r.serial_out == $past(core_tx_in) && evt_r.infrared_out == $past(txp_r)))
    else $error("event copy wrong");
  // slow receive only moves on its sample pulse
  chk_slow_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (slow_en && !fast_en && !ctrl_r[`CTRL_EVT_RX_EN] && !slow_sample_in)
    |=> $stable(rx_sel_r))
    else $error("slow receive moved between samples");
  // multi-step checks: a full filter run, and a trigger edge behind the synchronizer
  sequence s_filter_run;
    (filt_en && dm_r == uart_aux_pkg::DM_IDLE && !rx_pin_in)
    ##1 (filt_en && !rx_pin_in) [*4];
  endsequence
  sequence s_trig_edge;
    !trig_s_r ##1 trig_s_r;
  endsequence
  chk_filter_accept: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_filter_run |=> zero_seen_r)
    else $error("filtered pulse not accepted");
  chk_trig_rx: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (s_trig_edge ##0 ctrl_r[`CTRL_RX_TRIG_EN]) |=> rx_en_r)
    else $error("receive trigger missed");
endmodule : uart_irda_event_lowpower
`default_nettype wire

//--- dv/ir_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module ir_link_model (
  // clock
  input  wire logic       clk_in,
  // pulse request and width in clocks
  input  wire logic       fire_in,
  input  wire logic [3:0] width_in,
  // line toward the port, idles high
  output logic            line_out
);
  logic [3:0] left_r = 4'h0;  // low cycles still to send
  // a zero is one negative pulse; a request shorter than two clocks is stretched to two
  always_ff @(posedge clk_in) begin
    if (fire_in) begin
      left_r <= (width_in < 4'h2) ? 4'h2 : width_in;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
  assign line_out = (left_r == 4'h0);
endmodule : ir_link_model
`default_nettype wire

//--- dv/uart_irda_event_lowpower_tb.sv
`timescale 1ns/10ps
`default_nettype none
module uart_irda_event_lowpower_tb;
  logic        clk_in, sys_rst_in, cyc, we, ctx, rts, done_lvl, bs, tick, irq, slp;
  logic        rdma, tdma, erx, trig, fire, ss;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, r, seed;
  logic [4:0]  cnt;
  logic [3:0]  wdt;
  uart_aux_pkg::wake_cause_s cz;
  uart_aux_pkg::event_out_s  ev;
  wire logic [31:0] q;
  wire logic   ack, crx, txe, rxe, brk, wk, blk, pin, tpin;
  int          err_count, n_compared, lo_tx, lo_ir, lo_rx, n_wk, e;
  // design under test; select lanes are not exercised
  uart_irda_event_lowpower #(.FIFO_CNT_W(4)) uut (
    .clk_in, .sys_rst_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(q), .wb_ack_out(ack),
    .core_tx_in(ctx), .core_rts_in(rts), .core_txc_in(done_lvl), .rx_fifo_cnt_in(cnt),
    .bit_start_in(bs), .ovs_tick_in(tick), .slow_sample_in(ss), .wake_cause_in(cz),
    .irq_pending_in(irq), .rx_dma_req_in(rdma), .tx_dma_req_in(tdma),
    .deep_sleep_state_in(slp), .core_rx_out(crx), .tx_enable_out(txe), .rx_enable_out(rxe),
    .break_allow_out(brk), .wake_req_out(wk), .sleep_block_out(blk), .rx_pin_in(pin),
    .tx_pin_out(tpin), .evt_rx_in(erx), .evt_trig_in(trig), .evt_out(ev)
  );
  // remote infrared transmitter
  ir_link_model partner (.clk_in, .fire_in(fire), .width_in(wdt), .line_out(pin));
  initial begin
    clk_in = 1'h0;
    forever #10 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      $display("mismatch %s expected %0h seen %0h", s, x, g);
      err_count++;
    end
  endtask : chk
  task end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // one classic cycle; waits for ack however long it takes, the watchdog ends a dead bus
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'h1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'h1);
    rdat = q;
    cyc <= 1'h0;
    chk("wb_ack", 2, n);
  endtask : wb
  // counts low line cycles, low receive cycles and wake pulses
  task watch(input int n);
    lo_tx = 0;
    lo_ir = 0;
    lo_rx = 0;
    n_wk  = 0;
    repeat (n) begin
      @(negedge clk_in);
      lo_tx += int'(tpin === 1'h0);
      lo_ir += int'(ev.infrared_out === 1'h0);
      lo_rx += int'(crx === 1'h0);
      n_wk  += int'(wk === 1'h1);
    end
  endtask : watch
  // sends one bit from the core, also ends any held demodulated zero
  task mod_bit(input logic b);
    @(posedge clk_in);
    ctx <= b;
    bs  <= 1'h1;
    @(posedge clk_in);
    bs  <= 1'h0;
    watch(12);
    @(posedge clk_in);
    ctx <= 1'h1;
  endtask : mod_bit
  task wake_try(input logic [7:0] c, input logic [2:0] z, input logic i, input int x);
    wb(1'h1, 8'h00, {24'h0, c});
    @(posedge clk_in);
    cz  <= z;
    irq <= i;
    watch(6);
    chk("wake", x, n_wk);
    @(posedge clk_in);
    cz  <= 3'h0;
    irq <= 1'h0;
    watch(3);
  endtask : wake_try
  initial begin
    seed = 32'h5ba3_ab73;
    {cyc, we, bs, tick, irq, slp, rdma, tdma, trig, fire, done_lvl, ss} = '0;
    {sys_rst_in, ctx, rts, erx} = 4'hf;
    adr = 8'h00;
    dat = 32'h0;
    cnt = 5'h00;
    wdt = 4'h2;
    cz  = 3'h0;
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    @(negedge clk_in);
    chk("idle", 32'h0000_0af0, {ev, brk, tpin, crx, txe, rxe, wk, blk});
    for (int a = 0; a < 5; a++) rd_all: begin
      wb(1'h0, 8'(a * 4), 32'h0);
      chk("reg_reset", (a == 3) ? 32'h2 : 32'h0, rdat);
    end
    r = rnd() & 32'h0000_00ff;
    wb(1'h1, 8'h00, r);
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl", r, rdat);
    wb(1'h1, 8'h00, 32'h0);
    // random event levels; the first round puts the count right on the watermark
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      wb(1'h1, 8'h08, {28'h0, r[3:0]});
      @(posedge clk_in);
      ctx      <= r[4];
      done_lvl <= r[5];
      rts      <= r[6];
      cnt      <= (i == 0) ? {1'h0, r[3:0]} : r[12:8];
      @(posedge clk_in);
      @(negedge clk_in);
      chk("events", {r[4], r[5], r[6], cnt > r[3:0]}, {ev[4:3], ev[0], ev[1]});
    end
    @(posedge clk_in);
    ctx <= 1'h1;
    wb(1'h1, 8'h00, 32'h1);
    @(posedge clk_in);
    erx <= 1'h0;
    @(posedge clk_in);
    @(negedge clk_in);
    chk("sync", 1, crx);
    repeat (3) @(negedge clk_in);
    chk("evt_rx", 0, crx);
    wb(1'h1, 8'h00, 32'h0);
    repeat (4) @(negedge clk_in);
    chk("pin_rx", 1, crx);
    @(posedge clk_in);
    erx <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      wb(1'h1, 8'h00, 32'(2 * k));
      @(posedge clk_in);
      trig <= 1'h1;
      repeat (3) @(posedge clk_in);
      trig <= 1'h0;
      repeat (4) @(negedge clk_in);
      chk("trigger", (k == 0) ? 0 : k + 1, {txe, rxe});
    end
    // a wake bit holds off sleep only for its own direction's requests
    for (int k = 0; k < 4; k++) begin
      wb(1'h1, 8'h00, k[0] ? 32'h10 : 32'h08);
      @(posedge clk_in);
      rdma <= !k[1];
      tdma <= k[1];
      repeat (2) @(negedge clk_in);
      chk("block", k[0] == k[1], blk);
      @(posedge clk_in);
      {rdma, tdma} <= 2'h0;
      repeat (2) @(negedge clk_in);
      chk("unblock", 0, blk);
    end
    wb(1'h1, 8'h00, 32'h0);
    slp <= 1'h1;
    wake_try(8'h60, 3'h4, 1'h0, 1);
    wake_try(8'h60, 3'h2, 1'h0, 1);
    wake_try(8'h60, 3'h1, 1'h0, 1);
    wake_try(8'h20, 3'h4, 1'h0, 0);
    wake_try(8'h40, 3'h4, 1'h0, 0);
    wake_try(8'he0, 3'h0, 1'h1, 1);
    wake_try(8'h60, 3'h0, 1'h1, 0);
    wb(1'h1, 8'h00, 32'h0);
    slp  <= 1'h0;
    tick <= 1'h1;
    for (int n = 0; n < 5; n++) begin
      e = (n < 4) ? n + 1 : 1;
      wb(1'h1, 8'h04, (n < 4) ? 32'(1 + 8 * n) : 32'h61);
      mod_bit(1'h0);
      chk("pulse", e, lo_tx);
      chk("ir_event", e, lo_ir);
      chk("no_break", 0, brk);
      mod_bit(1'h1);
      chk("one_idle", 0, lo_tx);
    end
    // unfiltered short pulse, then the filter around its persistence limit
    for (int w = 1; w < 7; w++) begin
      wb(1'h1, 8'h04, (w == 1) ? 32'h1 : 32'h5);
      @(posedge clk_in);
      fire <= 1'h1;
      wdt  <= 4'((w == 1) ? 2 : w);
      @(posedge clk_in);
      fire <= 1'h0;
      watch(12);
      chk("demod", (w == 1) || (w > 4), lo_rx > 0);
      mod_bit(1'h1);
    end
    wb(1'h1, 8'h04, 32'h2);
    repeat (2) @(negedge clk_in);
    chk("slow_break", 0, brk);
    // slow receive holds its level between samples, then takes the held zero
    @(posedge clk_in);
    fire <= 1'h1;
    @(posedge clk_in);
    fire <= 1'h0;
    watch(8);
    chk("slow_hold", 0, lo_rx);
    @(posedge clk_in);
    ss <= 1'h1;
    @(posedge clk_in);
    ss <= 1'h0;
    watch(4);
    chk("slow_rx", 1, lo_rx > 0);
    wb(1'h1, 8'h04, 32'h0);
    repeat (2) @(negedge clk_in);
    chk("break", 1, brk);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    end_sim();
  end
endmodule : uart_irda_event_lowpower_tb
`default_nettype wire
